// File: pad_model.sv
// Board pad model: resolves pin levels from block, board drivers and pulls
`timescale 1ns/100ps
module pad_model (
  input  wire        clock,  // Clock
  input  wire  [7:0] oe,     // Block drives
  input  wire  [7:0] dout,   // Block level
  input  wire  [7:0] pu,     // Pull-up on
  input  wire  [7:0] pd,     // Pull-down on
  input  wire  [7:0] ext_en, // Board drives
  input  wire  [7:0] ext,    // Board level
  output logic [7:0] pin     // Pin level
);
  logic [7:0] flt_r = 8'h5a;
  // Undriven unpulled pins wander every cycle
  always @(posedge clock) flt_r <= ~flt_r;
  always_comb
    for (int i = 0; i < 8; i++)
      pin[i] = oe[i] ? dout[i] : ext_en[i] ? ext[i] : pu[i] ? 1'b1 : pd[i] ? 1'b0 : flt_r[i];
endmodule // pad_model

// File: pin_ctrl_defines.vh
// Register map, field masks, reset values and timing for the port M/P/Q pin control block
`ifndef PIN_CTRL_DEFINES_VH
`define PIN_CTRL_DEFINES_VH

// Register byte offsets on the APB bus
`define OFS_M_PIN_LEVEL      8'h00
`define OFS_M_DIRECTION      8'h04
`define OFS_M_DRIVE          8'h08
`define OFS_M_PULL_EN        8'h0c
`define OFS_M_PULL_POL       8'h10
`define OFS_M_OPEN_DRAIN     8'h14
`define OFS_P_LATCH          8'h18
`define OFS_P_PIN_LEVEL      8'h1c
`define OFS_P_DIRECTION      8'h20
`define OFS_P_DRIVE          8'h24
`define OFS_P_PULL_EN        8'h28
`define OFS_P_PULL_POL       8'h2c
`define OFS_Q_LATCH          8'h30

// Implemented bit positions per register
`define MASK_M_CTRL          8'hfb
`define MASK_M_OPEN_DRAIN    8'hf0
`define MASK_P               8'h3f
`define MASK_Q               8'h7f

// Port M pin groups taken over by peripherals
`define M_TWO_WIRE_PINS      8'hc0
`define M_DAC_PINS           8'h03
`define M_SCL_BIT            7
`define M_SDA_BIT            6
`define M_RX_BIT             4
`define M_TX_BIT             5

// Reset values
`define RST_M_PULL_EN        8'hf0
`define RST_ZERO             8'h00

// Bus answer timing
`define APB_WAIT_CYCLES      1

`endif

// File: pin_ctrl_monitor.sv
// Port-level assertions for the pin control block
`timescale 1ns/100ps
module pin_ctrl_monitor (
  input wire       clock,            // Clock
  input wire       arst_n,           // Reset
  input wire [1:0] analog_out_en,    // Analog on
  input wire       two_wire_en,      // Two-wire on
  input wire       two_wire_scl_low, // Clock low
  input wire       two_wire_sda_low, // Data low
  input wire       serial2_rx_en,    // Receiver on
  input wire [5:0] pwm_en,           // PWM on
  input wire [5:0] pwm_out,          // PWM level
  input wire [6:0] pwm_fault_in_en,  // Fault inputs on
  input wire [7:0] port_m_pins_out,  // M level
  input wire [7:0] port_m_pins_oe,   // M drive
  input wire [7:0] port_m_pull_up,   // M up
  input wire [7:0] port_m_pull_down, // M down
  input wire [7:0] port_p_pins_out,  // P level
  input wire [7:0] port_p_pins_oe,   // P drive
  input wire [7:0] port_p_reduced,   // P weak
  input wire [7:0] port_p_pull_up,   // P up
  input wire [7:0] port_p_pull_down, // P down
  input wire [7:0] port_q_pins_oe    // Q drive
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_pwm_drives: assert property (|pwm_en |=>
    (port_p_pins_oe[5:0] & $past(pwm_en)) == $past(pwm_en)
    && ((port_p_pins_out[5:0] ^ $past(pwm_out)) & $past(pwm_en)) == 6'h00)
    else $error("PWM pin not driven");
  a_fault_input: assert property (|pwm_fault_in_en |=>
    (port_q_pins_oe[6:0] & $past(pwm_fault_in_en)) == 7'h00)
    else $error("Fault pin driven");
  a_dac_output: assert property (|analog_out_en |=>
    (port_m_pins_oe[1:0] & $past(analog_out_en)) == $past(analog_out_en))
    else $error("Analog pin not output");
  a_two_wire_od: assert property (two_wire_en |=>
    port_m_pins_out[7:6] == 2'b00
    && port_m_pins_oe[7:6] == {$past(two_wire_scl_low), $past(two_wire_sda_low)})
    else $error("Two-wire pins not open drain");
  a_rx_input: assert property (serial2_rx_en |=> !port_m_pins_oe[4])
    else $error("Receive pin driven");
  a_p_top_idle: assert property (port_p_pins_oe[7:6] == 2'b00)
    else $error("Port P pin 7 or 6 driven");
  a_p_weak_out: assert property ((port_p_reduced & ~port_p_pins_oe) == 8'h00)
    else $error("Reduced drive on input");
  a_p_pull_in: assert property (((port_p_pull_up | port_p_pull_down) & port_p_pins_oe) == 8'h00)
    else $error("Pull on port P output");
  a_m_pull_excl: assert property ((port_m_pull_up & port_m_pull_down) == 8'h00)
    else $error("Pull-up and pull-down together");
  c_pwm: cover property (|pwm_en);
  c_two_wire: cover property (two_wire_en);
  c_fault: cover property (|pwm_fault_in_en);
endmodule // pin_ctrl_monitor

bind port_pin_control pin_ctrl_monitor mon_u (.clock, .arst_n, .analog_out_en, .two_wire_en,
  .two_wire_scl_low, .two_wire_sda_low, .serial2_rx_en, .pwm_en, .pwm_out, .pwm_fault_in_en,
  .port_m_pins_out, .port_m_pins_oe, .port_m_pull_up, .port_m_pull_down, .port_p_pins_out,
  .port_p_pins_oe, .port_p_reduced, .port_p_pull_up, .port_p_pull_down, .port_q_pins_oe);

// File: port_pin_control.v
// Port M/P/Q pin control: APB register file, peripheral overrides and pad controls
`timescale 1ns/100ps
`include "pin_ctrl_defines.vh"

module port_pin_control (
  input  wire        clock,              // System clock, 100 MHz
  input  wire        arst_n,             // Asynchronous reset, active low
  input  wire        psel,               // APB select
  input  wire        penable,            // APB access phase
  input  wire        pwrite,             // APB write when high
  input  wire [7:0]  paddr,              // APB byte address
  input  wire [31:0] pwdata,             // APB write data
  output reg  [31:0] prdata,             // APB read data
  output reg         pready,             // APB ready
  output reg         pslverr,            // APB error, unmapped address
  input  wire [7:0]  port_m_latch,       // Port M data latch, held elsewhere
  input  wire [7:0]  port_q_direction,   // Port Q direction, held elsewhere
  input  wire        two_wire_en,        // Two-wire module enabled
  input  wire        two_wire_scl_low,   // Two-wire pulls clock line low
  input  wire        two_wire_sda_low,   // Two-wire pulls data line low
  input  wire        serial2_tx_en,      // Serial channel 2 transmitter enabled
  input  wire        serial2_rx_en,      // Serial channel 2 receiver enabled
  input  wire        serial2_tx_data,    // Serial channel 2 transmit level
  input  wire [1:0]  analog_out_en,      // Analog output channels 1 and 0 enabled
  input  wire [5:0]  pwm_en,             // PWM channel enables
  input  wire [5:0]  pwm_out,            // PWM channel output levels
  input  wire [6:0]  pwm_fault_in_en,    // Fault and current-sense input enables
  input  wire [7:0]  port_m_pins_in,     // Port M pad input levels
  input  wire [7:0]  port_p_pins_in,     // Port P pad input levels
  input  wire [7:0]  port_q_pins_in,     // Port Q pad input levels
  output reg  [7:0]  port_m_pins_out,    // Port M pad output levels
  output reg  [7:0]  port_m_pins_oe,     // Port M pad drive enables
  output reg  [7:0]  port_m_reduced,     // Port M reduced drive
  output reg  [7:0]  port_m_pull_up,     // Port M pull-up on
  output reg  [7:0]  port_m_pull_down,   // Port M pull-down on
  output reg  [7:0]  port_p_pins_out,    // Port P pad output levels
  output reg  [7:0]  port_p_pins_oe,     // Port P pad drive enables
  output reg  [7:0]  port_p_reduced,     // Port P reduced drive
  output reg  [7:0]  port_p_pull_up,     // Port P pull-up on
  output reg  [7:0]  port_p_pull_down,   // Port P pull-down on
  output reg  [7:0]  port_q_pins_out,    // Port Q pad output levels
  output reg  [7:0]  port_q_pins_oe,     // Port Q pad drive enables
  output reg  [7:0]  port_m_level,       // Synchronised port M levels to peripherals
  output reg  [7:0]  port_q_level        // Synchronised port Q levels to peripherals
);

  // Software registers
  reg  [7:0]  m_dir_r;
  reg  [7:0]  m_drive_r;
  reg  [7:0]  m_pull_en_r;
  reg  [7:0]  m_pull_pol_r;
  reg  [7:0]  m_od_r;
  reg  [7:0]  p_latch_r;
  reg  [7:0]  p_dir_r;
  reg  [7:0]  p_drive_r;
  reg  [7:0]  p_pull_en_r;
  reg  [7:0]  p_pull_pol_r;
  reg  [7:0]  q_latch_r;

  // Pin synchronisers
  reg  [7:0]  m_meta_r;
  reg  [7:0]  p_meta_r;
  reg  [7:0]  q_meta_r;
  reg  [7:0]  m_sync_r;
  reg  [7:0]  p_sync_r;
  reg  [7:0]  q_sync_r;

  // Bus decode
  wire        access;
  wire        wr_done;
  reg  [31:0] rdata_nxt;
  reg         mapped_nxt;

  // Pad control next values
  reg  [7:0]  m_is_out;
  reg  [7:0]  m_is_od;
  reg  [7:0]  m_lvl;
  wire [7:0]  m_drv_low;
  wire [7:0]  m_out_nxt;
  wire [7:0]  m_oe_nxt;
  wire [7:0]  m_pull_on;
  wire [7:0]  m_up_nxt;
  wire [7:0]  m_down_nxt;
  wire [7:0]  m_weak_nxt;
  wire [7:0]  p_is_out;
  wire [7:0]  p_out_nxt;
  wire [7:0]  p_in_pull;
  wire [7:0]  p_up_nxt;
  wire [7:0]  p_down_nxt;
  wire [7:0]  p_weak_nxt;
  wire [7:0]  q_is_out;
  wire [7:0]  q_out_nxt;
  wire [7:0]  p_latch_read;
  wire [7:0]  q_latch_read;
  genvar      idx;

  // Two-stage synchronisers; only the second stage is read anywhere
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      m_meta_r <= `RST_ZERO;
      m_sync_r <= `RST_ZERO;
    end else begin
      m_meta_r <= port_m_pins_in;
      m_sync_r <= m_meta_r;
    end
  end

  // Port P synchroniser
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      p_meta_r <= `RST_ZERO;
      p_sync_r <= `RST_ZERO;
    end else begin
      p_meta_r <= port_p_pins_in;
      p_sync_r <= p_meta_r;
    end
  end

  // Port Q synchroniser
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q_meta_r <= `RST_ZERO;
      q_sync_r <= `RST_ZERO;
    end else begin
      q_meta_r <= port_q_pins_in;
      q_sync_r <= q_meta_r;
    end
  end

  // APB: one wait cycle, answer on the second access cycle
  assign access  = psel & penable;
  assign wr_done = access & pready & pwrite;

  always @* begin
    rdata_nxt  = 32'h0000_0000;
    mapped_nxt = 1'b1;
    if (paddr == `OFS_M_PIN_LEVEL) begin
      rdata_nxt[7:0] = m_sync_r;
    end else if (paddr == `OFS_M_DIRECTION) begin
      rdata_nxt[7:0] = m_dir_r;
    end else if (paddr == `OFS_M_DRIVE) begin
      rdata_nxt[7:0] = m_drive_r;
    end else if (paddr == `OFS_M_PULL_EN) begin
      rdata_nxt[7:0] = m_pull_en_r;
    end else if (paddr == `OFS_M_PULL_POL) begin
      rdata_nxt[7:0] = m_pull_pol_r;
    end else if (paddr == `OFS_M_OPEN_DRAIN) begin
      rdata_nxt[7:0] = m_od_r;
    end else if (paddr == `OFS_P_LATCH) begin
      rdata_nxt[7:0] = p_latch_read;
    end else if (paddr == `OFS_P_PIN_LEVEL) begin
      rdata_nxt[7:0] = p_sync_r & `MASK_P;
    end else if (paddr == `OFS_P_DIRECTION) begin
      rdata_nxt[7:0] = p_dir_r;
    end else if (paddr == `OFS_P_DRIVE) begin
      rdata_nxt[7:0] = p_drive_r;
    end else if (paddr == `OFS_P_PULL_EN) begin
      rdata_nxt[7:0] = p_pull_en_r;
    end else if (paddr == `OFS_P_PULL_POL) begin
      rdata_nxt[7:0] = p_pull_pol_r;
    end else if (paddr == `OFS_Q_LATCH) begin
      rdata_nxt[7:0] = q_latch_read;
    end else begin
      mapped_nxt = 1'b0;
    end
  end

  // Data latch readback picks latch or live pin per direction bit
  assign p_latch_read = ((p_latch_r & p_dir_r) | (p_sync_r & ~p_dir_r)) & `MASK_P;
  assign q_latch_read = ((q_latch_r & port_q_direction) |
                         (q_sync_r & ~port_q_direction)) & `MASK_Q;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~mapped_nxt;
      prdata  <= (access & ~pready & ~pwrite) ? rdata_nxt : 32'h0000_0000;
    end
  end

  // Register writes; pin level offsets have no write path
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      m_dir_r      <= `RST_ZERO;
      m_drive_r    <= `RST_ZERO;
      m_pull_en_r  <= `RST_M_PULL_EN;
      m_pull_pol_r <= `RST_ZERO;
      m_od_r       <= `RST_ZERO;
      p_latch_r    <= `RST_ZERO;
      p_dir_r      <= `RST_ZERO;
      p_drive_r    <= `RST_ZERO;
      p_pull_en_r  <= `RST_ZERO;
      p_pull_pol_r <= `RST_ZERO;
      q_latch_r    <= `RST_ZERO;
    end else if (wr_done) begin
      if (paddr == `OFS_M_DIRECTION) begin
        m_dir_r <= pwdata[7:0] & `MASK_M_CTRL;
      end else if (paddr == `OFS_M_DRIVE) begin
        m_drive_r <= pwdata[7:0] & `MASK_M_CTRL;
      end else if (paddr == `OFS_M_PULL_EN) begin
        m_pull_en_r <= pwdata[7:0] & `MASK_M_CTRL;
      end else if (paddr == `OFS_M_PULL_POL) begin
        m_pull_pol_r <= pwdata[7:0] & `MASK_M_CTRL;
      end else if (paddr == `OFS_M_OPEN_DRAIN) begin
        m_od_r <= pwdata[7:0] & `MASK_M_OPEN_DRAIN;
      end else if (paddr == `OFS_P_LATCH) begin
        p_latch_r <= pwdata[7:0] & `MASK_P;
      end else if (paddr == `OFS_P_DIRECTION) begin
        p_dir_r <= pwdata[7:0] & `MASK_P;
      end else if (paddr == `OFS_P_DRIVE) begin
        p_drive_r <= pwdata[7:0] & `MASK_P;
      end else if (paddr == `OFS_P_PULL_EN) begin
        p_pull_en_r <= pwdata[7:0] & `MASK_P;
      end else if (paddr == `OFS_P_PULL_POL) begin
        p_pull_pol_r <= pwdata[7:0] & `MASK_P;
      end else if (paddr == `OFS_Q_LATCH) begin
        q_latch_r <= pwdata[7:0] & `MASK_Q;
      end
    end
  end

  // Port M: direction bits only read here, never rewritten by overrides
  always @* begin
    m_is_out = m_dir_r;
    m_is_od  = m_od_r;
    m_lvl    = port_m_latch;
    if (two_wire_en) begin
      m_is_out[`M_SCL_BIT] = two_wire_scl_low;
      m_is_out[`M_SDA_BIT] = two_wire_sda_low;
      m_is_od[`M_SCL_BIT]  = 1'b1;
      m_is_od[`M_SDA_BIT]  = 1'b1;
      m_lvl[`M_SCL_BIT]    = 1'b0;
      m_lvl[`M_SDA_BIT]    = 1'b0;
    end
    if (serial2_tx_en) begin
      m_is_out[`M_TX_BIT] = 1'b1;
      m_lvl[`M_TX_BIT]    = serial2_tx_data;
    end
    if (serial2_rx_en) begin
      m_is_out[`M_RX_BIT] = 1'b0;
    end
    if (analog_out_en[1]) begin
      m_is_out[1] = 1'b1;
      m_lvl[1]    = 1'b0;
    end
    if (analog_out_en[0]) begin
      m_is_out[0] = 1'b1;
      m_lvl[0]    = 1'b0;
    end
  end

  // Port M per pin; an open-drain output drives only the low level
  generate
    for (idx = 0; idx < 8; idx = idx + 1) begin : g_port_m
      assign m_drv_low[idx]  = m_is_od[idx] & m_is_out[idx];
      assign m_oe_nxt[idx]   = m_is_out[idx] & ~(m_drv_low[idx] & m_lvl[idx]);
      assign m_out_nxt[idx]  = m_lvl[idx] & ~m_drv_low[idx];
      // Pull stays on for open-drain outputs, whose high level floats
      assign m_pull_on[idx]  = m_pull_en_r[idx] & (~m_is_out[idx] | m_is_od[idx]);
      assign m_up_nxt[idx]   = m_pull_on[idx] & ~m_pull_pol_r[idx];
      assign m_down_nxt[idx] = m_pull_on[idx] & m_pull_pol_r[idx];
      assign m_weak_nxt[idx] = m_drive_r[idx] & m_is_out[idx];
    end
  endgenerate

  // Port P: enabled PWM channel owns its pin
  generate
    for (idx = 0; idx < 8; idx = idx + 1) begin : g_port_p
      if (idx < 6) begin : g_pin
        assign p_is_out[idx]   = pwm_en[idx] | p_dir_r[idx];
        assign p_out_nxt[idx]  = pwm_en[idx] ? pwm_out[idx] : p_latch_r[idx];
        assign p_in_pull[idx]  = p_pull_en_r[idx] & ~p_is_out[idx];
        assign p_up_nxt[idx]   = p_in_pull[idx] & ~p_pull_pol_r[idx];
        assign p_down_nxt[idx] = p_in_pull[idx] & p_pull_pol_r[idx];
        assign p_weak_nxt[idx] = p_drive_r[idx] & p_is_out[idx];
      // Missing pins stay inputs with every pad control off
      end else begin : g_none
        assign p_is_out[idx]   = 1'b0;
        assign p_out_nxt[idx]  = 1'b0;
        assign p_in_pull[idx]  = 1'b0;
        assign p_up_nxt[idx]   = 1'b0;
        assign p_down_nxt[idx] = 1'b0;
        assign p_weak_nxt[idx] = 1'b0;
      end
    end
  endgenerate

  // Port Q: enabled fault or current-sense input forces input
  generate
    for (idx = 0; idx < 8; idx = idx + 1) begin : g_port_q
      if (idx < 7) begin : g_pin
        assign q_is_out[idx]  = port_q_direction[idx] & ~pwm_fault_in_en[idx];
        assign q_out_nxt[idx] = q_latch_r[idx] & q_is_out[idx];
      // Missing pin stays an input
      end else begin : g_none
        assign q_is_out[idx]  = 1'b0;
        assign q_out_nxt[idx] = 1'b0;
      end
    end
  endgenerate

  // Registered port M pad controls and level feed
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      port_m_pins_out  <= `RST_ZERO;
      port_m_pins_oe   <= `RST_ZERO;
      port_m_reduced   <= `RST_ZERO;
      port_m_pull_up   <= `RST_M_PULL_EN;
      port_m_pull_down <= `RST_ZERO;
      port_m_level     <= `RST_ZERO;
    end else begin
      port_m_pins_out  <= m_out_nxt;
      port_m_pins_oe   <= m_oe_nxt;
      port_m_reduced   <= m_weak_nxt;
      port_m_pull_up   <= m_up_nxt;
      port_m_pull_down <= m_down_nxt;
      port_m_level     <= m_sync_r;
    end
  end

  // Registered port P pad controls
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      port_p_pins_out  <= `RST_ZERO;
      port_p_pins_oe   <= `RST_ZERO;
      port_p_reduced   <= `RST_ZERO;
      port_p_pull_up   <= `RST_ZERO;
      port_p_pull_down <= `RST_ZERO;
    end else begin
      port_p_pins_out  <= p_out_nxt;
      port_p_pins_oe   <= p_is_out;
      port_p_reduced   <= p_weak_nxt;
      port_p_pull_up   <= p_up_nxt;
      port_p_pull_down <= p_down_nxt;
    end
  end

  // Registered port Q pad controls and level feed
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      port_q_pins_out <= `RST_ZERO;
      port_q_pins_oe  <= `RST_ZERO;
      port_q_level    <= `RST_ZERO;
    end else begin
      port_q_pins_out <= q_out_nxt;
      port_q_pins_oe  <= q_is_out;
      port_q_level    <= q_sync_r & `MASK_Q;
    end
  end

endmodule // port_pin_control

// File: testbench.sv
// Self-checking bench for the port pin control block
`timescale 1ns/100ps
`include "pin_ctrl_defines.vh"
module testbench;
  logic        clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, port_m_latch = 8'h00, port_q_direction = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        two_wire_en = 1'b0, two_wire_scl_low = 1'b0, two_wire_sda_low = 1'b0;
  logic        serial2_tx_en = 1'b0, serial2_rx_en = 1'b0, serial2_tx_data = 1'b1;
  logic [1:0]  analog_out_en = 2'b00;
  logic [5:0]  pwm_en = 6'h00, pwm_out = 6'h00;
  logic [6:0]  pwm_fault_in_en = 7'h00;
  logic [7:0]  ext_m = 8'h00, ext_p = 8'h00, ext_q = 8'h00;
  wire  [31:0] prdata;
  wire         pready, pslverr;
  wire  [7:0]  port_m_pins_in, port_p_pins_in, port_q_pins_in, port_m_pins_out, port_m_pins_oe;
  wire  [7:0]  port_m_pull_up, port_m_pull_down, port_p_pins_out, port_p_pins_oe;
  wire  [7:0]  port_p_reduced, port_p_pull_up, port_p_pull_down, port_q_pins_out, port_q_pins_oe;
  wire  [7:0]  port_m_reduced, port_m_level, port_q_level;
  int          mismatches = 0;
  int          n_checks = 0;
  logic [7:0]  ofs [11] = '{`OFS_M_DIRECTION, `OFS_M_DRIVE, `OFS_M_PULL_EN, `OFS_M_PULL_POL,
    `OFS_M_OPEN_DRAIN, `OFS_P_LATCH, `OFS_P_DIRECTION, `OFS_P_DRIVE, `OFS_P_PULL_EN,
    `OFS_P_PULL_POL, `OFS_Q_LATCH};
  logic [7:0]  msk [11] = '{8'hfb, 8'hfb, 8'hfb, 8'hfb, 8'hf0, 8'h3f, 8'h3f, 8'h3f, 8'h3f,
    8'h3f, 8'h7f};

  port_pin_control dut_u (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .port_m_latch, .port_q_direction, .two_wire_en, .two_wire_scl_low,
    .two_wire_sda_low, .serial2_tx_en, .serial2_rx_en, .serial2_tx_data, .analog_out_en,
    .pwm_en, .pwm_out, .pwm_fault_in_en, .port_m_pins_in, .port_p_pins_in, .port_q_pins_in,
    .port_m_pins_out, .port_m_pins_oe, .port_m_reduced, .port_m_pull_up, .port_m_pull_down,
    .port_p_pins_out, .port_p_pins_oe, .port_p_reduced, .port_p_pull_up, .port_p_pull_down,
    .port_q_pins_out, .port_q_pins_oe, .port_m_level, .port_q_level);
  pad_model pad_m (.clock, .oe(port_m_pins_oe), .dout(port_m_pins_out), .pu(port_m_pull_up),
    .pd(port_m_pull_down), .ext_en(8'hff), .ext(ext_m), .pin(port_m_pins_in));
  pad_model pad_p (.clock, .oe(port_p_pins_oe), .dout(port_p_pins_out), .pu(port_p_pull_up),
    .pd(port_p_pull_down), .ext_en(8'hff), .ext(ext_p), .pin(port_p_pins_in));
  pad_model pad_q (.clock, .oe(port_q_pins_oe), .dout(port_q_pins_out), .pu(8'h00),
    .pd(8'h00), .ext_en(8'h7f), .ext(ext_q), .pin(port_q_pins_in));

  initial forever #5 clock = ~clock;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, {24'hffffff, d}, q, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q[7:0], exp);
    chk({7'h00, e} | q[31:24] | q[23:16] | q[15:8], 8'h00);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic t_reset;
    chk(port_m_pull_up, 8'hf0);
    chk(port_m_pins_oe | port_p_pins_oe | port_q_pins_oe, 8'h00);
  endtask
  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    rd_chk(`OFS_M_PULL_EN, 8'hf0);
    port_q_direction <= 8'h7f;
    for (int i = 0; i < 11; i++) wr(ofs[i], 8'hff);
    for (int i = 0; i < 11; i++) rd_chk(ofs[i], msk[i]);
    apb(1'b1, 8'h34, 32'hff, q, e);
    chk({7'h00, e}, 8'h01);
    for (int i = 0; i < 11; i++) wr(ofs[i], 8'h00);
    port_q_direction <= 8'h00;
  endtask
  task automatic t_readback;
    ext_m <= 8'ha5;
    ext_p <= 8'h3c;
    ext_q <= 8'h96;
    wr(`OFS_M_PIN_LEVEL, 8'h5a);
    wr(`OFS_P_DIRECTION, 8'h0f);
    wr(`OFS_P_LATCH, 8'h05);
    settle(5);
    rd_chk(`OFS_M_PIN_LEVEL, 8'ha5);
    rd_chk(`OFS_P_LATCH, 8'h35);
    rd_chk(`OFS_P_PIN_LEVEL, 8'h35);
    rd_chk(`OFS_Q_LATCH, 8'h16);
    chk(port_m_level, 8'ha5);
    chk(port_q_level, 8'h16);
    chk(port_p_pins_oe, 8'h0f);
  endtask
  task automatic t_pwm;
    pwm_en <= 6'h21;
    pwm_out <= 6'h20;
    settle(3);
    chk(port_p_pins_oe, 8'h2f);
    chk(port_p_pins_out, 8'h24);
    rd_chk(`OFS_P_DIRECTION, 8'h0f);
    pwm_en <= 6'h00;
    settle(3);
    chk(port_p_pins_oe, 8'h0f);
  endtask
  task automatic t_m_over;
    port_m_latch <= 8'hff;
    wr(`OFS_M_DIRECTION, 8'hfb);
    {two_wire_en, two_wire_scl_low, serial2_rx_en, serial2_tx_en, serial2_tx_data} <= 5'h1e;
    analog_out_en <= 2'b11;
    settle(3);
    chk(port_m_pins_oe, 8'hab);
    chk(port_m_pins_out, 8'h1c);
    rd_chk(`OFS_M_DIRECTION, 8'hfb);
    wr(`OFS_M_OPEN_DRAIN, 8'hf0);
    {two_wire_en, serial2_rx_en, serial2_tx_en} <= 3'b000;
    analog_out_en <= 2'b00;
    wr(`OFS_M_PULL_EN, 8'h30);
    wr(`OFS_M_PULL_POL, 8'h10);
    wr(`OFS_M_DRIVE, 8'h81);
    settle(3);
    chk(port_m_pins_oe, 8'h0b);
    chk(port_m_pins_out, 8'h0f);
    chk(port_m_reduced, 8'h81);
    chk(port_m_pull_up, 8'h20);
    chk(port_m_pull_down, 8'h10);
  endtask
  task automatic t_p_pull_q;
    wr(`OFS_P_PULL_EN, 8'h3f);
    wr(`OFS_P_PULL_POL, 8'h11);
    wr(`OFS_P_DRIVE, 8'h3f);
    wr(`OFS_Q_LATCH, 8'h55);
    port_q_direction <= 8'h7f;
    pwm_fault_in_en <= 7'h0f;
    settle(3);
    chk(port_p_pull_up, 8'h20);
    chk(port_p_pull_down, 8'h10);
    chk(port_p_reduced, 8'h0f);
    chk(port_q_pins_oe, 8'h70);
    chk(port_q_pins_out, 8'h50);
    rd_chk(`OFS_Q_LATCH, 8'h55);
    pwm_fault_in_en <= 7'h00;
    settle(3);
    chk(port_q_pins_oe, 8'h7f);
    chk(port_q_pins_out, 8'h55);
  endtask

  initial begin
    repeat (16) @(posedge clock);
    t_reset();
    arst_n <= 1'b1;
    t_regs();
    t_readback();
    t_pwm();
    t_m_over();
    t_p_pull_q();
    arst_n <= 1'b0;
    settle(2);
    t_reset();
    report_and_stop();
  end
  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end
endmodule // testbench
